// file: src/acc_regs.vh
// register offsets, field positions and reset values of the converter control
`ifndef ACC_REGS_VH
`define ACC_REGS_VH
`define ACC_OFS_SC1 6'h00
`define ACC_OFS_SC2 6'h04
`define ACC_OFS_CFG 6'h08
`define ACC_OFS_CMP 6'h0c
`define ACC_OFS_RESH 6'h10
`define ACC_OFS_RESL 6'h14
`define ACC_OFS_PIN3 6'h18
`define ACC_OFS_PIN2 6'h1c
`define ACC_OFS_PIN1 6'h20
`define ACC_SC1_CONT 5
`define ACC_SC1_IEN 6
`define ACC_SC1_CONVERSION_COMPLETE_FLAG 7
`define ACC_SC2_HWT 0
`define ACC_SC2_CMPEN 1
`define ACC_SC2_CMPGT 2
`define ACC_SC2_ACT 3
`define ACC_CH_OFF 5'h1f
`define ACC_SRC_BUS 2'h0
`define ACC_SRC_HALF 2'h1
`define ACC_SRC_ALT 2'h2
`define ACC_SRC_ASYNC 2'h3
`define ACC_RES_8 2'h0
`define ACC_RES_12 2'h1
`define ACC_RES_10 2'h2
`define ACC_RST_CH 5'h1f
`define ACC_RST_CFG 8'h00
`endif

// file: src/acc_conversion_control.v
// converter control: register slave, clocking, pin control, triggering
//
// Design decisions made here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`include "acc_regs.vh"

module acc_conversion_control #(
  parameter PINS = 24
) (
  input wire sys_clk,
  input wire srst,
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire alternate_clock,
  input wire internal_async_clock,
  input wire hardware_trigger_input,
  input wire [PINS-1:0] port_pin_level,
  output reg [PINS-1:0] pin_disable,
  output reg [PINS-1:0] port_read_data,
  output reg converter_clock,
  output reg internal_async_enable,
  output reg conv_enable,
  output reg conv_start,
  output reg conv_abort,
  output reg [4:0] conv_channel,
  output reg conv_raw_9bit,
  input wire conv_done,
  input wire [11:0] conv_raw,
  output reg conversion_irq
);

  localparam ST_OFF = 3'b001;
  localparam ST_IDLE = 3'b010;
  localparam ST_BUSY = 3'b100;

  // ----------------------------------------------------------------
  // result sizing
  // ----------------------------------------------------------------
  // round half up and saturate so a full-scale value cannot wrap to zero
  function [11:0] acc_size;
    input [11:0] raw;
    input [1:0] res;
    begin
      case (res)
        `ACC_RES_10: begin
          if (raw[11:2] == 10'h3ff)
            acc_size = 12'h3ff;
          else
            acc_size = {2'h0, raw[11:2] + {9'h000, raw[1]}};
        end
        `ACC_RES_8: begin
          if (raw[8:1] == 8'hff)
            acc_size = 12'h0ff;
          else
            acc_size = {4'h0, raw[8:1] + {7'h00, raw[0]}};
        end
        default: acc_size = raw;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [4:0] channel_select_field;
  reg continuous;
  reg completion_interrupt_enable;
  reg conversion_complete_flag;
  reg hardware_trigger_enable;
  reg compare_enable;
  reg compare_greater;
  reg [1:0] clock_source_select;
  reg [1:0] resolution;
  reg [1:0] clock_divide_select;
  reg [11:0] compare_value;
  reg [11:0] result;
  reg [7:0] analog_pin_disable_ch16_23;
  reg [7:0] analog_pin_disable_ch8_15;
  reg [7:0] analog_pin_disable_ch0_7;
  reg [2:0] state;
  reg cont_run;

  wire bus_wr = avs_write && !avs_waitrequest;
  wire bus_rd = avs_read && !avs_waitrequest;
  wire wr_b0 = bus_wr && avs_byteenable[0];
  wire wr_sc1 = wr_b0 && avs_address == `ACC_OFS_SC1;
  wire wr_mode = bus_wr && (avs_address == `ACC_OFS_SC2 ||
                 avs_address == `ACC_OFS_CFG || avs_address == `ACC_OFS_CMP);
  wire [4:0] new_ch = avs_writedata[4:0];

  // ----------------------------------------------------------------
  // avalon slave: one wait cycle, then answer
  // ----------------------------------------------------------------
  reg [31:0] next_readdata;
  always @* begin
    next_readdata = 32'h00000000;
    case (avs_address)
      `ACC_OFS_SC1: next_readdata[7:0] = {conversion_complete_flag,
        completion_interrupt_enable, continuous, channel_select_field};
      `ACC_OFS_SC2: next_readdata[3:0] = {state == ST_BUSY, compare_greater,
        compare_enable, hardware_trigger_enable};
      `ACC_OFS_CFG: next_readdata[6:0] = {clock_divide_select, 1'b0,
        resolution, clock_source_select};
      `ACC_OFS_CMP: next_readdata[11:0] = compare_value;
      `ACC_OFS_RESH: next_readdata[3:0] = result[11:8];
      `ACC_OFS_RESL: next_readdata[7:0] = result[7:0];
      `ACC_OFS_PIN3: next_readdata[7:0] = analog_pin_disable_ch16_23;
      `ACC_OFS_PIN2: next_readdata[7:0] = analog_pin_disable_ch8_15;
      `ACC_OFS_PIN1: next_readdata[7:0] = analog_pin_disable_ch0_7;
      default: next_readdata = 32'h00000000;
    endcase
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= next_readdata;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      channel_select_field <= `ACC_RST_CH;
      continuous <= 1'b0;
      completion_interrupt_enable <= 1'b0;
      hardware_trigger_enable <= 1'b0;
      compare_enable <= 1'b0;
      compare_greater <= 1'b0;
      {clock_divide_select, resolution, clock_source_select} <= 6'h00;
      compare_value <= 12'h000;
      analog_pin_disable_ch16_23 <= 8'h00;
      analog_pin_disable_ch8_15 <= 8'h00;
      analog_pin_disable_ch0_7 <= 8'h00;
    end else if (wr_b0) begin
      case (avs_address)
        `ACC_OFS_SC1: begin
          channel_select_field <= new_ch;
          continuous <= avs_writedata[`ACC_SC1_CONT];
          completion_interrupt_enable <= avs_writedata[`ACC_SC1_IEN];
        end
        `ACC_OFS_SC2: begin
          hardware_trigger_enable <= avs_writedata[`ACC_SC2_HWT];
          compare_enable <= avs_writedata[`ACC_SC2_CMPEN];
          compare_greater <= avs_writedata[`ACC_SC2_CMPGT];
        end
        `ACC_OFS_CFG: begin
          clock_source_select <= avs_writedata[1:0];
          resolution <= avs_writedata[3:2];
          clock_divide_select <= avs_writedata[6:5];
        end
        `ACC_OFS_CMP: begin
          compare_value[7:0] <= avs_writedata[7:0];
          if (avs_byteenable[1])
            compare_value[11:8] <= avs_writedata[11:8];
        end
        `ACC_OFS_PIN3: analog_pin_disable_ch16_23 <= avs_writedata[7:0];
        `ACC_OFS_PIN2: analog_pin_disable_ch8_15 <= avs_writedata[7:0];
        `ACC_OFS_PIN1: analog_pin_disable_ch0_7 <= avs_writedata[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin control
  // ----------------------------------------------------------------
  reg [PINS-1:0] pin_s1;
  reg [PINS-1:0] pin_s2;
  wire [23:0] pin_all = {analog_pin_disable_ch16_23,
                         analog_pin_disable_ch8_15, analog_pin_disable_ch0_7};
  always @(posedge sys_clk) begin
    if (srst) begin
      pin_s1 <= {PINS{1'b0}};
      pin_s2 <= {PINS{1'b0}};
      pin_disable <= {PINS{1'b0}};
      port_read_data <= {PINS{1'b0}};
    end else begin
      pin_s1 <= port_pin_level;
      pin_s2 <= pin_s1;
      pin_disable <= pin_all[PINS-1:0];
      port_read_data <= pin_s2 & ~pin_all[PINS-1:0];
    end
  end

  // ----------------------------------------------------------------
  // converter clock
  // ----------------------------------------------------------------
  // external clocks are sampled, so they must be well below sys_clk
  reg alt_s1, alt_s2, alt_s3;
  reg asy_s1, asy_s2, asy_s3;
  reg half_phase;
  reg [1:0] act_src;
  reg [1:0] act_div;
  reg [2:0] div_cnt;
  reg src_tick;
  always @* begin
    case (act_src)
      `ACC_SRC_BUS: src_tick = 1'b1;
      `ACC_SRC_HALF: src_tick = half_phase;
      `ACC_SRC_ALT: src_tick = alt_s2 && !alt_s3;
      default: src_tick = asy_s2 && !asy_s3;
    endcase
  end
  wire [2:0] div_last = (3'h1 << act_div) - 3'h1;

  always @(posedge sys_clk) begin
    if (srst) begin
      {alt_s1, alt_s2, alt_s3} <= 3'h0;
      {asy_s1, asy_s2, asy_s3} <= 3'h0;
      half_phase <= 1'b0;
      act_src <= `ACC_SRC_BUS;
      act_div <= 2'h0;
      div_cnt <= 3'h0;
      converter_clock <= 1'b0;
      internal_async_enable <= 1'b0;
    end else begin
      {alt_s1, alt_s2, alt_s3} <= {alternate_clock, alt_s1, alt_s2};
      {asy_s1, asy_s2, asy_s3} <= {internal_async_clock, asy_s1, asy_s2};
      half_phase <= !half_phase;
      internal_async_enable <= clock_source_select == `ACC_SRC_ASYNC &&
                               state != ST_OFF;
      if (src_tick) begin
        if (div_cnt >= div_last) begin
          div_cnt <= 3'h0;
          converter_clock <= !converter_clock;
          if (converter_clock) begin
            act_src <= clock_source_select;
            act_div <= clock_divide_select;
          end
        end else begin
          div_cnt <= div_cnt + 3'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // triggering and sequencing
  // ----------------------------------------------------------------
  reg trg_s1, trg_s2, trg_s3;
  wire trg_rise = trg_s2 && !trg_s3;
  wire [11:0] sized = acc_size(conv_raw, resolution);
  wire cmp_ok = !compare_enable ||
                (compare_greater ? sized >= compare_value :
                                   sized < compare_value);
  wire hw_go = hardware_trigger_enable && trg_rise && state == ST_IDLE &&
               !cont_run;
  wire sw_go = wr_sc1 && new_ch != `ACC_CH_OFF &&
               !hardware_trigger_enable;
  wire done = state == ST_BUSY && conv_done;
  wire store = done && cmp_ok;
  wire restart = done && (continuous || (cmp_ok == 1'b0 && continuous));
  wire res_lo_rd = bus_rd && avs_address == `ACC_OFS_RESL;

  reg [2:0] next_state;
  always @* begin
    next_state = state;
    case (state)
      ST_OFF: next_state = sw_go ? ST_BUSY : ST_IDLE;
      ST_IDLE: if (sw_go || hw_go) next_state = ST_BUSY;
      ST_BUSY: begin
        if (wr_sc1 || wr_mode)
          next_state = sw_go ? ST_BUSY : ST_IDLE;
        else if (done && !continuous)
          next_state = ST_IDLE;
      end
      default: next_state = ST_OFF;
    endcase
    if (channel_select_field == `ACC_CH_OFF && !sw_go)
      next_state = ST_OFF;
    if (wr_sc1 && new_ch == `ACC_CH_OFF)
      next_state = ST_OFF;
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      {trg_s1, trg_s2, trg_s3} <= 3'h0;
      state <= ST_OFF;
      cont_run <= 1'b0;
      conv_start <= 1'b0;
      conv_abort <= 1'b0;
      conv_enable <= 1'b0;
      conv_channel <= `ACC_RST_CH;
      conv_raw_9bit <= 1'b1;
      result <= 12'h000;
      conversion_complete_flag <= 1'b0;
      conversion_irq <= 1'b0;
    end else begin
      {trg_s1, trg_s2, trg_s3} <= {hardware_trigger_input, trg_s1, trg_s2};
      state <= next_state;
      if (wr_sc1 || wr_mode || next_state == ST_OFF)
        cont_run <= 1'b0;
      else if (hw_go && continuous)
        cont_run <= 1'b1;
      conv_start <= next_state == ST_BUSY &&
                    (state != ST_BUSY || sw_go || restart);
      conv_abort <= state == ST_BUSY && (wr_sc1 || wr_mode);
      conv_enable <= next_state != ST_OFF;
      conv_channel <= channel_select_field;
      conv_raw_9bit <= resolution == `ACC_RES_8;
      if (store)
        result <= sized;
      // a completion in the cycle of a clear still sets the flag
      if (store)
        conversion_complete_flag <= 1'b1;
      else if (wr_sc1 || res_lo_rd)
        conversion_complete_flag <= 1'b0;
      conversion_irq <= (conversion_complete_flag || store) &&
                        !(wr_sc1 && !store) && !(res_lo_rd && !store) &&
                        (wr_sc1 ? avs_writedata[`ACC_SC1_IEN] :
                         completion_interrupt_enable);
    end
  end

endmodule

// file: tb/acc_conversion_control_sva.sv
// port assertions for the converter control block
`timescale 1ns/1ps
`include "acc_regs.vh"
module acc_conversion_control_sva #(
  parameter PINS = 24
) (
  input wire sys_clk,
  input wire srst,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire hardware_trigger_input,
  input wire [PINS-1:0] pin_disable,
  input wire [PINS-1:0] port_read_data,
  input wire internal_async_enable,
  input wire conv_enable,
  input wire conv_start,
  input wire [4:0] conv_channel,
  input wire conv_done,
  input wire conversion_irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  wire wr_done = avs_write && !avs_waitrequest;
  a_bus_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  a_pin_change: assert property (
    !$stable(pin_disable) |-> $past(wr_done) || $past(wr_done, 2))
    else $error("pin disable changed without write");
  a_read_zero: assert property (
    (port_read_data & pin_disable & $past(pin_disable)) == 0)
    else $error("disabled pin reads one");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start longer than one cycle");
  a_start_cause: assert property (conv_start |-> $past(wr_done) ||
    $past(conv_done) || $past(hardware_trigger_input, 3) ||
    $past(hardware_trigger_input, 4) || $past(hardware_trigger_input, 5))
    else $error("start without cause");
  a_off_idle: assert property (
    conv_channel == `ACC_CH_OFF && $past(conv_channel) == `ACC_CH_OFF |->
    !$past(conv_enable) && !$past(conv_start))
    else $error("converter active while off");
  a_async_on: assert property (
    internal_async_enable |-> conv_enable || $past(conv_enable))
    else $error("async clock on while off");
  a_irq_cause: assert property ($rose(conversion_irq) |->
    $past(conv_done) || $past(conv_done, 2) || $past(wr_done) ||
    $past(wr_done, 2))
    else $error("interrupt without completion");
endmodule
bind acc_conversion_control acc_conversion_control_sva #(.PINS(PINS)) u_sva (
  .sys_clk(sys_clk), .srst(srst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .hardware_trigger_input(hardware_trigger_input),
  .pin_disable(pin_disable), .port_read_data(port_read_data),
  .internal_async_enable(internal_async_enable),
  .conv_enable(conv_enable), .conv_start(conv_start),
  .conv_channel(conv_channel), .conv_done(conv_done),
  .conversion_irq(conversion_irq));

// file: tb/acc_core_model.sv
// behavioural model of the analog converter core
`timescale 1ns/1ps
module acc_core_model #(
  parameter DELAY = 40
) (
  input wire sys_clk,
  input wire srst,
  input wire conv_start,
  input wire conv_abort,
  input wire conv_raw_9bit,
  input wire [11:0] raw_value,
  output reg conv_done,
  output reg [11:0] conv_raw
);
  integer cnt;
  always @(posedge sys_clk) begin
    conv_done <= 1'b0;
    // raw bus churns outside done so a stale sample cannot pass
    conv_raw <= srst ? 12'h5a5 : ~conv_raw;
    // a start beside an abort is a restart, so the start wins
    if (srst) cnt <= 0;
    else if (conv_start) cnt <= DELAY;
    else if (conv_abort) cnt <= 0;
    else if (cnt == 1) begin
      cnt <= 0;
      conv_done <= 1'b1;
      conv_raw <= conv_raw_9bit ? {3'h0, raw_value[8:0]} : raw_value;
    end else if (cnt > 1) cnt <= cnt - 1;
  end
endmodule

// file: tb/tb.sv
// self-checking bench of the converter control block
`timescale 1ns/1ps
`include "acc_regs.vh"
module tb;
  reg sys_clk = 0, srst = 1, avs_read = 0, avs_write = 0;
  reg [5:0] avs_address = 0;
  reg [31:0] avs_writedata = 0, rd;
  reg [3:0] avs_byteenable = 4'hf;
  reg alt_clk = 0, async_clk = 0, trig = 0, done_q = 0;
  reg [23:0] pins = 0;
  reg [11:0] raw_value = 0;
  wire [31:0] avs_readdata;
  wire [23:0] pin_disable, port_read_data;
  wire [11:0] conv_raw;
  wire avs_waitrequest, internal_async_enable, conv_enable, conv_start;
  wire conv_abort, conv_raw_9bit, conv_done, conversion_irq, cclk;
  integer bad_count = 0, checked = 0, stray = 0, starts = 0, s0, p;
  acc_conversion_control u_acc_conversion_control (.sys_clk(sys_clk),
    .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .alternate_clock(alt_clk),
    .internal_async_clock(async_clk), .hardware_trigger_input(trig),
    .port_pin_level(pins), .pin_disable(pin_disable),
    .port_read_data(port_read_data), .converter_clock(cclk),
    .internal_async_enable(internal_async_enable),
    .conv_enable(conv_enable), .conv_start(conv_start),
    .conv_abort(conv_abort), .conv_channel(), .conv_raw_9bit(conv_raw_9bit),
    .conv_done(conv_done), .conv_raw(conv_raw),
    .conversion_irq(conversion_irq));
  acc_core_model u_acc_core_model (.sys_clk(sys_clk), .srst(srst),
    .conv_start(conv_start), .conv_abort(conv_abort),
    .conv_raw_9bit(conv_raw_9bit), .raw_value(raw_value),
    .conv_done(conv_done), .conv_raw(conv_raw));
  initial forever #50 sys_clk = ~sys_clk;
  initial forever #400 alt_clk = ~alt_clk;
  initial forever #370 async_clk = ~async_clk;
  // a stray start is one not launched by the completion before it
  always @(posedge sys_clk) begin
    if (conv_start === 1'b1) begin
      starts = starts + 1;
      if (!done_q) stray = stray + 1;
    end
    done_q <= conv_done;
  end
  task results;
    begin
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  task check(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task bus(input wr, input [5:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      n = 0;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0 && n < 20) begin
        n = n + 1;
        @(posedge sys_clk);
      end
      rd = avs_readdata;
      avs_write <= 0;
      avs_read <= 0;
      if (n == 20) begin
        bad_count = bad_count + 1;
        results;
      end
    end
  endtask
  task wait_irq;
    integer n;
    begin
      n = 0;
      while (conversion_irq !== 1'b1 && n < 300) begin
        n = n + 1;
        @(posedge sys_clk);
      end
      if (n == 300) begin
        bad_count = bad_count + 1;
        results;
      end
    end
  endtask
  // cycles between the second and third rising edge of the core clock
  task period;
    integer n, e;
    reg q;
    begin
      e = 0;
      n = 0;
      q = cclk;
      while (e < 3 && n < 300) begin
        @(posedge sys_clk);
        n = n + 1;
        p = p + 1;
        if (cclk && !q) begin
          e = e + 1;
          if (e < 3) p = 0;
        end
        q = cclk;
      end
      if (n == 300) begin
        bad_count = bad_count + 1;
        results;
      end
    end
  endtask
  task t_reset;
    begin
      bus(0, `ACC_OFS_CFG, 0);
      check(rd, 0);
      bus(0, `ACC_OFS_SC1, 0);
      check(rd[4:0], 5'h1f);
      check(conv_enable, 0);
      bus(0, 6'h3c, 0);
      check(rd, 0);
    end
  endtask
  task t_pins;
    begin
      pins <= 24'hffffff;
      bus(1, `ACC_OFS_PIN3, 32'ha5);
      repeat (4) @(posedge sys_clk);
      check(pin_disable[23:16], 8'ha5);
      check(port_read_data, 24'h5affff);
      bus(0, `ACC_OFS_PIN3, 0);
      check(rd, 32'ha5);
    end
  endtask
  task t_conv(input [1:0] res, input [11:0] raw, input [3:0] hi,
              input [7:0] lo);
    begin
      raw_value <= raw;
      bus(1, `ACC_OFS_CFG, {res, 2'b00});
      repeat (2) @(posedge sys_clk);
      check(conv_raw_9bit, res == `ACC_RES_8);
      s0 = starts;
      bus(1, `ACC_OFS_SC1, 32'h43);
      wait_irq;
      bus(0, `ACC_OFS_SC1, 0);
      check(rd[7], 1);
      bus(0, `ACC_OFS_RESH, 0);
      if (res != `ACC_RES_8) check(rd, hi);
      bus(0, `ACC_OFS_RESL, 0);
      check(rd, lo);
      repeat (2) @(posedge sys_clk);
      check(conversion_irq, 0);
      check(starts - s0, 1);
    end
  endtask
  task t_cmp;
    begin
      raw_value <= 12'h7ff;
      bus(1, `ACC_OFS_CFG, 32'h4);
      bus(1, `ACC_OFS_CMP, 32'h800);
      bus(1, `ACC_OFS_SC2, 32'h6);
      bus(1, `ACC_OFS_SC1, 32'h3);
      repeat (60) @(posedge sys_clk);
      bus(0, `ACC_OFS_SC1, 0);
      check(rd[7], 0);
      bus(0, `ACC_OFS_RESL, 0);
      check(rd, 32'h5c);
      bus(1, `ACC_OFS_CMP, 32'h7ff);
      bus(1, `ACC_OFS_SC1, 32'h43);
      wait_irq;
      bus(0, `ACC_OFS_RESL, 0);
      check(rd, 32'hff);
    end
  endtask
  task t_clk;
    integer s, d;
    begin
      for (s = 0; s < 2; s = s + 1)
        for (d = 0; d < 4; d = d + 1) begin
          bus(1, `ACC_OFS_CFG, (d << 5) | s);
          period;
          check(p, (2 << d) << s);
        end
      bus(1, `ACC_OFS_CFG, `ACC_SRC_ASYNC);
      repeat (3) @(posedge sys_clk);
      check(internal_async_enable, 1);
      bus(1, `ACC_OFS_CFG, `ACC_SRC_ALT);
      repeat (3) @(posedge sys_clk);
      check(internal_async_enable, 0);
    end
  endtask
  task pulse;
    begin
      @(posedge sys_clk) trig <= 1;
      repeat (3) @(posedge sys_clk);
      trig <= 0;
      repeat (8) @(posedge sys_clk);
    end
  endtask
  task t_hw;
    begin
      bus(1, `ACC_OFS_SC2, 32'h1);
      s0 = starts;
      bus(1, `ACC_OFS_SC1, 32'h43);
      repeat (4) @(posedge sys_clk);
      check(starts - s0, 0);
      pulse;
      check(starts - s0, 1);
      pulse;
      check(starts - s0, 1);
      wait_irq;
      bus(0, `ACC_OFS_RESL, 0);
      bus(1, `ACC_OFS_SC1, 32'h23);
      stray = 0;
      pulse;
      repeat (100) @(posedge sys_clk);
      pulse;
      repeat (100) @(posedge sys_clk);
      check(stray, 1);
      check(starts - s0 > 3, 1);
      bus(1, `ACC_OFS_SC1, 32'h1f);
      s0 = starts;
      repeat (100) @(posedge sys_clk);
      check(conv_enable, 0);
      check(starts - s0, 0);
    end
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    srst <= 0;
    t_reset;
    t_pins;
    t_conv(`ACC_RES_12, 12'hab6, 4'ha, 8'hb6);
    t_conv(`ACC_RES_10, 12'hab6, 4'h2, 8'hae);
    t_conv(`ACC_RES_10, 12'hffe, 4'h3, 8'hff);
    t_conv(`ACC_RES_8, 12'h0b7, 4'h0, 8'h5c);
    t_cmp;
    t_clk;
    t_hw;
    results;
  end
endmodule
